// file: rtl/async_timer_prescaler_compare_output.sv
// Timer clock source, prescaler, counter and two compare-output waveform channels
`timescale 1ns/1ps
module async_timer_prescaler_compare_output
    import tmr_pkg::*;
(
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Oscillator pins
    input  wire logic        osc_in_pin,
    output logic             osc_out_pin_o,
    output logic             osc_out_pin_oe,
    output logic             osc_pins_detached,
    // Port data-direction bits of the two wave pins
    input  wire logic        chan_a_dir,
    input  wire logic        chan_b_dir,
    // Wave outputs
    output logic             chan_a_wave_out,
    output logic             chan_a_wave_oe,
    output logic             chan_a_port_override,
    output logic             chan_b_wave_out,
    output logic             chan_b_wave_oe,
    output logic             chan_b_port_override
);

    // Tap decode of the prescaler
    function automatic logic tap_hit(input logic [2:0] cs, input logic src,
                                     input logic [9:0] pre);
        logic hit;
        hit = 1'b0;
        case (cs)
            3'd0:    hit = 1'b0;
            3'd1:    hit = src;
            3'd2:    hit = src & (&pre[2:0]);
            3'd3:    hit = src & (&pre[4:0]);
            3'd4:    hit = src & (&pre[5:0]);
            3'd5:    hit = src & (&pre[6:0]);
            3'd6:    hit = src & (&pre[7:0]);
            default: hit = src & (&pre[9:0]);
        endcase
        return hit;
    endfunction

    // Output action of one channel for the present count
    function automatic act_e chan_act(input logic [1:0] com, input logic pwm_tog,
                                      input wave_e wm, input logic [7:0] cnt,
                                      input logic [7:0] ocr, input logic [7:0] top,
                                      input logic down);
        logic match;
        logic at_top;
        logic special;
        act_e act;
        match   = (cnt == ocr);
        at_top  = (cnt == top);
        special = (ocr == top) && com[1];
        act     = ACT_NONE;
        case (wm)
            WM_FAST_FF, WM_FAST_OC:
            begin
                if (com == 2'b01)
                begin
                    if (pwm_tog && match)
                        act = ACT_TOG;
                end
                else if (com[1])
                begin
                    if (match && !special)
                        act = com[0] ? ACT_SET : ACT_CLR;
                    else if (at_top)
                        act = com[0] ? ACT_CLR : ACT_SET;
                end
            end
            WM_PC_FF, WM_PC_OCR:
            begin
                if (com == 2'b01)
                begin
                    if (pwm_tog && match)
                        act = ACT_TOG;
                end
                else if (com[1])
                begin
                    if (special)
                    begin
                        if (at_top)
                            act = com[0] ? ACT_CLR : ACT_SET;
                    end
                    else if (match)
                    begin
                        if (down && cnt != CNT_BOTTOM) // The turn at BOTTOM acts as up-count
                            act = com[0] ? ACT_CLR : ACT_SET;
                        else
                            act = com[0] ? ACT_SET : ACT_CLR;
                    end
                end
            end
            default:
            begin
                if (match)
                    act = act_e'(com);
            end
        endcase
        return act;
    endfunction

    // Apply an action to a pin level
    function automatic logic apply_act(input act_e act, input logic cur);
        logic nv;
        nv = cur;
        case (act)
            ACT_TOG: nv = ~cur;
            ACT_CLR: nv = 1'b0;
            ACT_SET: nv = 1'b1;
            default: nv = cur;
        endcase
        return nv;
    endfunction

    // Software-visible state
    ctrl_a_s     ctrl_a;
    logic        wgm_top;
    logic [2:0]  clk_sel;
    logic [7:0]  cmp_a;
    logic [7:0]  cmp_b;
    logic        async_sel;
    logic        ext_clk_en;
    logic        psr_pulse;

    // Timer state
    logic [9:0]  pre;
    logic [7:0]  cnt;
    logic        down;
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_s3;

    // Bus decode
    wire         acc     = psel & penable;
    wire         wr_take = acc & pwrite & pready;
    wire         hit_a   = (paddr == ADDR_CTRL_A);
    wire         hit_b   = (paddr == ADDR_CTRL_B);
    wire         hit_ca  = (paddr == ADDR_CMP_A);
    wire         hit_cb  = (paddr == ADDR_CMP_B);
    wire         hit_as  = (paddr == ADDR_ASYNC);
    wire         hit_gt  = (paddr == ADDR_GTC);
    wire         hit_cn  = (paddr == ADDR_COUNT);
    wire         mapped  = hit_a | hit_b | hit_ca | hit_cb | hit_as | hit_gt | hit_cn;

    // Read mux; reserved bits stay zero
    logic [7:0]  rd_byte;
    assign rd_byte = hit_a  ? (ctrl_a & CTRL_A_WMASK) :
                     hit_b  ? {4'h0, wgm_top, clk_sel} :
                     hit_ca ? cmp_a :
                     hit_cb ? cmp_b :
                     hit_as ? {1'b0, ext_clk_en, async_sel, 5'h00} :
                     hit_cn ? cnt : 8'h00;

    // Source tick: every pclk when synchronous, else a synced osc edge
    wire         osc_edge = osc_s2 & ~osc_s3;
    wire         src_tick = async_sel ? osc_edge : 1'b1;
    wire         tmr_tick = tap_hit(clk_sel, src_tick, pre);

    // Mode and TOP selection
    wire wave_e  wmode   = wave_e'({wgm_top, ctrl_a.wgm_lo});
    wire         pc_mode = (wmode == WM_PC_FF) | (wmode == WM_PC_OCR);
    wire         ocr_top = (wmode == WM_CTC) | (wmode == WM_PC_OCR) | (wmode == WM_FAST_OC);
    wire [7:0]   top     = ocr_top ? cmp_a : CNT_MAX;

    // Counter step
    logic [7:0]  next_cnt;
    logic        next_down;
    always_comb
    begin
        next_cnt  = cnt;
        next_down = down;
        if (pc_mode)
        begin
            if (down && cnt == CNT_BOTTOM)
            begin
                next_down = 1'b0;
                next_cnt  = cnt + 8'h01;
            end
            else if (!down && cnt >= top)
            begin
                next_down = 1'b1;
                next_cnt  = cnt - 8'h01;
            end
            else
                next_cnt = down ? cnt - 8'h01 : cnt + 8'h01;
        end
        else
        begin
            next_down = 1'b0;
            next_cnt  = (cnt == top) ? CNT_BOTTOM : cnt + 8'h01;
        end
    end

    // Channel actions
    wire act_e   act_a = chan_act(ctrl_a.com_a, wgm_top, wmode, cnt, cmp_a, top, down);
    wire act_e   act_b = chan_act(ctrl_a.com_b, 1'b0, wmode, cnt, cmp_b, top, down);
    wire         ovr_a = |ctrl_a.com_a;
    wire         ovr_b = |ctrl_a.com_b;

    // APB handshake: one wait state, then answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= acc & ~pready;
            prdata  <= (acc & ~pwrite & ~pready) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            pslverr <= acc & ~pready & ~mapped;
        end
    end

    // Register writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_a     <= CTRL_A_RESET;
            wgm_top    <= 1'b0;
            clk_sel    <= 3'b000;
            cmp_a      <= 8'h00;
            cmp_b      <= 8'h00;
            async_sel  <= 1'b0;
            ext_clk_en <= 1'b0;
            psr_pulse  <= 1'b0;
        end
        else
        begin
            psr_pulse <= wr_take & hit_gt & pwdata[GTC_PSR_BIT];
            if (wr_take & hit_a)
                ctrl_a <= pwdata[7:0] & CTRL_A_WMASK;
            if (wr_take & hit_b)
            begin
                wgm_top <= pwdata[CTRL_B_TOP_BIT];
                clk_sel <= pwdata[2:0];
            end
            if (wr_take & hit_ca)
                cmp_a <= pwdata[7:0];
            if (wr_take & hit_cb)
                cmp_b <= pwdata[7:0];
            if (wr_take & hit_as)
            begin
                async_sel  <= pwdata[ASYNC_SEL_BIT];
                ext_clk_en <= pwdata[ASYNC_EXT_BIT];
            end
        end
    end

    // Oscillator pin synchroniser; s1 feeds only s2
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end
        else
        begin
            osc_s1 <= osc_in_pin;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end

    // Prescaler; a reset request clears it so the phase is known
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre <= PRE_RESET;
        else if (psr_pulse)
            pre <= PRE_RESET;
        else if (src_tick)
            pre <= pre + 10'h001;
    end

    // Counter; a software write wins over a timer tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt  <= CNT_BOTTOM;
            down <= 1'b0;
        end
        else if (wr_take & hit_cn)
            cnt <= pwdata[7:0];
        else if (tmr_tick)
        begin
            cnt  <= next_cnt;
            down <= next_down;
        end
    end

    // Wave levels change only on timer ticks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chan_a_wave_out <= 1'b0;
            chan_b_wave_out <= 1'b0;
        end
        else if (tmr_tick)
        begin
            chan_a_wave_out <= apply_act(act_a, chan_a_wave_out);
            chan_b_wave_out <= apply_act(act_b, chan_b_wave_out);
        end
    end

    // Pin override, driver enables and oscillator pins; only a crystal gets the far pin driven
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chan_a_port_override <= 1'b0;
            chan_b_port_override <= 1'b0;
            chan_a_wave_oe       <= 1'b0;
            chan_b_wave_oe       <= 1'b0;
            osc_pins_detached    <= 1'b0;
            osc_out_pin_oe       <= 1'b0;
            osc_out_pin_o        <= 1'b0;
        end
        else
        begin
            chan_a_port_override <= ovr_a;
            chan_b_port_override <= ovr_b;
            chan_a_wave_oe       <= ovr_a & chan_a_dir;
            chan_b_wave_oe       <= ovr_b & chan_b_dir;
            osc_pins_detached    <= async_sel;
            osc_out_pin_oe       <= async_sel & ~ext_clk_en;
            osc_out_pin_o        <= ~osc_s2;
        end
    end

endmodule

// file: pkg/tmr_pkg.sv
// Register map, field layouts and encodings of the asynchronous timer output block
package tmr_pkg;

    // Register byte addresses on the APB
    localparam logic [7:0] ADDR_CTRL_A = 8'hB0;
    localparam logic [7:0] ADDR_CTRL_B = 8'hB4;
    localparam logic [7:0] ADDR_CMP_A  = 8'hB8;
    localparam logic [7:0] ADDR_CMP_B  = 8'hBC;
    localparam logic [7:0] ADDR_ASYNC  = 8'hC0;
    localparam logic [7:0] ADDR_GTC    = 8'hC4;
    localparam logic [7:0] ADDR_COUNT  = 8'hC8;

    // Field positions
    localparam int CTRL_B_TOP_BIT  = 3;
    localparam int ASYNC_EXT_BIT   = 6;
    localparam int ASYNC_SEL_BIT   = 5;
    localparam int GTC_PSR_BIT     = 1;

    // Reset values and counter landmarks
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
    localparam logic [7:0] CNT_BOTTOM   = 8'h00;
    localparam logic [7:0] CNT_MAX      = 8'hFF;
    localparam logic [9:0] PRE_RESET    = 10'h000;

    // Nominal oscillator figures, for reference only
    localparam int OSC_CRYSTAL_HZ = 32768;
    localparam int OSC_EXT_HZ     = 32000;

    // Control register A layout
    typedef struct packed {
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic [1:0] rsv;
        logic [1:0] wgm_lo;
    } ctrl_a_s;

    // Waveform modes, top bit first
    typedef enum logic [2:0] {
        WM_NORMAL  = 3'b000,
        WM_PC_FF   = 3'b001,
        WM_CTC     = 3'b010,
        WM_FAST_FF = 3'b011,
        WM_RSV4    = 3'b100,
        WM_PC_OCR  = 3'b101,
        WM_RSV6    = 3'b110,
        WM_FAST_OC = 3'b111
    } wave_e;

    // Output pin actions
    typedef enum logic [1:0] {
        ACT_NONE = 2'b00,
        ACT_TOG  = 2'b01,
        ACT_CLR  = 2'b10,
        ACT_SET  = 2'b11
    } act_e;

endpackage

// file: tb/async_timer_prescaler_compare_output_monitor.sv
// Port-level property checker for the timer output block
`timescale 1ns/1ps
module async_timer_prescaler_compare_output_monitor
    import tmr_pkg::*;
(
    // APB side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pin side
    input wire logic        osc_out_pin_oe,
    input wire logic        osc_pins_detached,
    input wire logic        chan_a_dir,
    input wire logic        chan_b_dir,
    input wire logic        chan_a_wave_oe,
    input wire logic        chan_a_port_override,
    input wire logic        chan_b_wave_oe,
    input wire logic        chan_b_port_override
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus answer timing and quiet read data
    a_ready_second: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata nonzero outside answer");
    a_rsv_zero: assert property (pready && !pwrite && paddr == ADDR_CTRL_A |->
        prdata[31:8] == 24'h0 && prdata[3:2] == 2'h0)
        else $error("reserved control bits read nonzero");
    // Driver enable needs both a live mode and the direction bit; checked once both settle
    a_oe_dir_a: assert property ($stable(chan_a_dir) && $stable(chan_a_port_override) |->
        chan_a_wave_oe == (chan_a_port_override && chan_a_dir))
        else $error("channel a enable mismatch");
    a_oe_dir_b: assert property ($stable(chan_b_dir) && $stable(chan_b_port_override) |->
        chan_b_wave_oe == (chan_b_port_override && chan_b_dir))
        else $error("channel b enable mismatch");
    a_osc_detach: assert property (osc_out_pin_oe |-> osc_pins_detached)
        else $error("oscillator driven while pins attached");

    // Main scenarios reached
    c_ctrl_write: cover property (pready && pwrite && paddr == ADDR_CTRL_A);
    c_err: cover property (pslverr);
    c_osc: cover property (osc_out_pin_oe);
endmodule

bind async_timer_prescaler_compare_output async_timer_prescaler_compare_output_monitor mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_out_pin_oe(osc_out_pin_oe), .osc_pins_detached(osc_pins_detached),
    .chan_a_dir(chan_a_dir), .chan_b_dir(chan_b_dir), .chan_a_wave_oe(chan_a_wave_oe),
    .chan_a_port_override(chan_a_port_override), .chan_b_wave_oe(chan_b_wave_oe),
    .chan_b_port_override(chan_b_port_override));

// file: tb/async_timer_prescaler_compare_output_test.sv
// Self-checking bench for the timer output block
`timescale 1ns/1ps
module async_timer_prescaler_compare_output_test
    import tmr_pkg::*;
;
    localparam logic [7:0] MODE_TAB [3] = '{8'h70, 8'hA0, 8'hD0};
    logic        pclk, presetn, psel, penable, pwrite, osc_in, dir_a, dir_b, err;
    logic        pready, pslverr, osc_o, osc_oe, osc_det;
    logic        wave_a, oe_a, ovr_a, wave_b, oe_b, ovr_b;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, q0;
    int          n_mismatch, n_checks;

    // Free-running 250 MHz clock
    initial
    begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end

    async_timer_prescaler_compare_output DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_in_pin(osc_in), .osc_out_pin_o(osc_o), .osc_out_pin_oe(osc_oe),
        .osc_pins_detached(osc_det), .chan_a_dir(dir_a), .chan_b_dir(dir_b),
        .chan_a_wave_out(wave_a), .chan_a_wave_oe(oe_a), .chan_a_port_override(ovr_a),
        .chan_b_wave_out(wave_b), .chan_b_wave_oe(oe_b), .chan_b_port_override(ovr_b));

    // One APB transfer; an idle edge at the end keeps back-to-back calls race free
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'h1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1)
            @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic t_regs;
        xfer(1'h0, ADDR_CTRL_A, 32'h0);
        chk("ctrl_a reset", q, {24'h0, CTRL_A_RESET});
        xfer(1'h1, ADDR_CTRL_A, 32'hFF);
        xfer(1'h0, ADDR_CTRL_A, 32'h0);
        chk("ctrl_a readback", q, 32'hF3);
        xfer(1'h0, 8'hFC, 32'h0);
        chk("unmapped err", 32'(err), 32'h1);
        $display("test regs done");
    endtask

    // Channel a's compare mode is live but the counter is stopped, so only the override shows
    task automatic t_override;
        dir_a <= 1'h1;
        repeat (3) @(posedge pclk);
        chk("override a", 32'(ovr_a), 32'h1);
        chk("enable a", 32'(oe_a), 32'h1);
        chk("enable b", 32'(oe_b), 32'h0);
        xfer(1'h1, ADDR_CTRL_A, 32'h0);
        repeat (2) @(posedge pclk);
        chk("override b off", 32'(ovr_b), 32'h0);
        $display("test override done");
    endtask

    // Each phase restarts from zero and runs past both compare values once
    task automatic t_compare;
        xfer(1'h1, ADDR_CMP_A, 32'h3);
        xfer(1'h1, ADDR_CMP_B, 32'h5);
        for (int i = 0; i < 3; i++)
        begin
            xfer(1'h1, ADDR_CTRL_B, 32'h0);
            xfer(1'h1, ADDR_CTRL_A, {24'h0, MODE_TAB[i]});
            xfer(1'h1, ADDR_COUNT, 32'h0);
            xfer(1'h1, ADDR_CTRL_B, 32'h1);
            repeat (20) @(posedge pclk);
            chk("wave a", 32'(wave_a), 32'(i != 1));
            chk("wave b", 32'(wave_b), 32'(i != 1));
        end
        xfer(1'h1, ADDR_CTRL_B, 32'h0);
        $display("test compare done");
    endtask

    task automatic t_prescale;
        xfer(1'h1, ADDR_CTRL_B, 32'h2);
        xfer(1'h1, ADDR_GTC, 32'h1 << GTC_PSR_BIT);
        xfer(1'h1, ADDR_COUNT, 32'h0);
        repeat (80) @(posedge pclk);
        xfer(1'h0, ADDR_COUNT, 32'h0);
        chk("div8 count", 32'(q >= 9 && q <= 12), 32'h1);
        xfer(1'h1, ADDR_CTRL_B, 32'h0);
        xfer(1'h0, ADDR_COUNT, 32'h0);
        q0 = q;
        repeat (20) @(posedge pclk);
        xfer(1'h0, ADDR_COUNT, 32'h0);
        chk("stopped count", q, q0);
        $display("test prescale done");
    endtask

    // With the pin still the counter must not move; then ten rising pin edges give ten counts
    task automatic t_async;
        xfer(1'h1, ADDR_ASYNC, 32'h1 << ASYNC_SEL_BIT);
        xfer(1'h1, ADDR_CTRL_B, 32'h1);
        xfer(1'h1, ADDR_COUNT, 32'h0);
        chk("detached", 32'(osc_det), 32'h1);
        chk("osc drive", 32'(osc_oe), 32'h1);
        repeat (40) @(posedge pclk);
        xfer(1'h0, ADDR_COUNT, 32'h0);
        chk("count pin idle", q, 32'h0);
        for (int i = 0; i < 10; i++)
        begin
            osc_in <= 1'h1;
            repeat (4) @(posedge pclk);
            osc_in <= 1'h0;
            repeat (4) @(posedge pclk);
        end
        repeat (8) @(posedge pclk);
        xfer(1'h0, ADDR_COUNT, 32'h0);
        chk("count pin edges", q, 32'hA);
        osc_in <= 1'h1;
        repeat (4) @(posedge pclk);
        chk("osc out high in", 32'(osc_o), 32'h0);
        osc_in <= 1'h0;
        repeat (4) @(posedge pclk);
        chk("osc out low in", 32'(osc_o), 32'h1);
        xfer(1'h1, ADDR_ASYNC, 32'h3 << ASYNC_SEL_BIT);
        @(posedge pclk);
        chk("ext clock drive", 32'(osc_oe), 32'h0);
        xfer(1'h1, ADDR_ASYNC, 32'h0);
        @(posedge pclk);
        chk("attached", 32'(osc_det), 32'h0);
        $display("test async done");
    endtask

    // Run undivided for n cycles plus the bus time, stop, and read the count into q
    task automatic run_for(input int n);
        xfer(1'h1, ADDR_CTRL_B, 32'h1);
        repeat (n) @(posedge pclk);
        xfer(1'h1, ADDR_CTRL_B, 32'h0);
        xfer(1'h0, ADDR_COUNT, 32'h0);
    endtask

    // Fast PWM levels follow where the stopped count lies against each compare value;
    // phase correct runs stop at chosen points of the up and down slopes
    task automatic t_pwm;
        dir_b <= 1'h1;
        xfer(1'h1, ADDR_CTRL_B, 32'h0);
        xfer(1'h1, ADDR_CMP_A, 32'h40);
        xfer(1'h1, ADDR_CMP_B, 32'h20);
        xfer(1'h1, ADDR_CTRL_A, 32'hE3);
        xfer(1'h1, ADDR_COUNT, 32'hF8);
        chk("enable b on", 32'(oe_b), 32'h1);
        for (int i = 0; i < 2; i++)
        begin
            run_for(20 + 40 * i);
            chk("fast a inverting", 32'(wave_a), 32'(q[7:0] > 8'h40));
            chk("fast b", 32'(wave_b), 32'(q[7:0] <= 8'h20));
        end
        xfer(1'h1, ADDR_CTRL_A, 32'hB1);
        xfer(1'h1, ADDR_CMP_B, 32'h0);
        xfer(1'h1, ADDR_COUNT, 32'h30);
        run_for(20);
        chk("pc a up", 32'(wave_a), 32'h0);
        run_for(400);
        chk("pc a down", 32'(wave_a), 32'h1);
        run_for(100);
        chk("pc a up again", 32'(wave_a), 32'h0);
        chk("pc b bottom", 32'(wave_b), 32'h1);
        xfer(1'h1, ADDR_CMP_A, 32'hFF);
        run_for(520);
        chk("pc a at top", 32'(wave_a), 32'h1);
        chk("pc b steady", 32'(wave_b), 32'h1);
        $display("test pwm done");
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence after five reset cycles
    initial
    begin
        {psel, penable, pwrite, osc_in, dir_a, dir_b, presetn} = 7'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        n_mismatch = 0;
        n_checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_regs;
        t_override;
        t_compare;
        t_prescale;
        t_async;
        t_pwm;
        complete_run;
    end

    // Whole run needs about two thousand cycles
    initial
    begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        complete_run;
    end
endmodule
